//--- hw/reset_and_clock_select.v
// reset sequencing and instruction clock selection, with an apb register slave
`timescale 1ns/100ps
`include "reset_and_clock_select_regs.vh"

module reset_and_clock_select (
    // apb clock and reset; pclk stands for the fast internal oscillator
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // reset sources
    input  wire        ext_reset_n_pin,
    input  wire        watchdog_overflow,
    // slow internal oscillator, one pulse per period
    input  wire        slow_internal_osc,
    // system side
    output reg         sys_reset_n,
    output reg         sys_init,
    output reg         cpu_run,
    output reg         cpu_start,
    output reg  [9:0]  start_address,
    output reg         fcpu_tick,
    output reg         low_clock_active
);

// ============================================================
// sequencer states, one-hot
localparam [3:0] ST_HOLD = 4'h1;   // waiting for reset pin release
localparam [3:0] ST_INIT = 4'h2;   // system registers loaded
localparam [3:0] ST_WARM = 4'h4;   // oscillator warm-up
localparam [3:0] ST_RUN  = 4'h8;   // program executing

// ============================================================
// declarations
reg  [3:0]  state;            // sequencer state
reg  [3:0]  next_state;       // sequencer next state
reg  [10:0] warm_count;       // warm-up period counter
reg         pin_meta;         // first synchroniser stage
reg         pin_sync;         // second synchroniser stage
reg         low_clock_select; // oscillator_mode_reg clock mode bit
reg  [2:0]  div_code;         // divider code option, 2^(code+1)
reg         rst_pin_enable;   // reset pin function option
reg         cause_pin;        // sticky: set by any pin reset
reg         cause_wdt;        // sticky: set by any watchdog reset
reg  [7:0]  fast_count;       // normal mode divider counter
reg  [1:0]  slow_count;       // slow mode divider counter
wire        pin_reset;        // qualified pin reset request
wire        wr_en;            // apb write takes effect
wire        rd_setup;         // apb read setup cycle
wire        addr_ok;          // address hits a register
wire [7:0]  fast_last;        // terminal count of fast divider
wire [31:0] rd_value;         // read mux output

// ============================================================
// reset pin synchroniser; the second stage alone is used
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_meta <= 1'b0;
        pin_sync <= 1'b0;
    end else begin
        pin_meta <= ext_reset_n_pin;
        pin_sync <= pin_meta;
    end
end

// low level means reset; ignored when disabled
assign pin_reset = rst_pin_enable & ~pin_sync;

// ============================================================
// sequencer next state
always @* begin
    next_state = state;
    case (state)
        ST_HOLD: begin
            if (!pin_reset) begin
                next_state = ST_INIT;
            end
        end
        ST_INIT: begin
            next_state = ST_WARM;
        end
        ST_WARM: begin
            if (warm_count == `RCS_WARM_LAST) begin
                next_state = ST_RUN;
            end
        end
        ST_RUN: begin
            next_state = ST_RUN;
        end
        default: begin
            next_state = ST_HOLD;
        end
    endcase
    // pin reset in any state, including warm-up
    if (pin_reset) begin
        next_state = ST_HOLD;
    end else if (watchdog_overflow && (state == ST_RUN || state == ST_WARM)) begin
        next_state = ST_INIT;
    end
end

// ============================================================
// sequencer registers; power-up starts in hold so the pin is checked first
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state      <= ST_HOLD;
        warm_count <= 11'h000;
    end else begin
        state <= next_state;
        // counter only advances while warming, restarts otherwise
        if (state == ST_WARM && next_state == ST_WARM) begin
            warm_count <= warm_count + 11'h001;
        end else begin
            warm_count <= 11'h000;
        end
    end
end

// ============================================================
// system side outputs, all registered
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sys_reset_n   <= 1'b0;
        sys_init      <= 1'b0;
        cpu_run       <= 1'b0;
        cpu_start     <= 1'b0;
        start_address <= `RCS_RESET_VECTOR;
    end else begin
        sys_reset_n   <= (next_state == ST_RUN);
        sys_init      <= (next_state == ST_INIT);
        cpu_run       <= (next_state == ST_RUN);
        cpu_start     <= (next_state == ST_RUN) && (state != ST_RUN);
        start_address <= `RCS_RESET_VECTOR;
    end
end

// ============================================================
// apb decode; slave never inserts wait states
assign pready   = 1'b1;
assign addr_ok  = (paddr == `RCS_OSC_MODE_ADDR) || (paddr == `RCS_CONFIG_ADDR) ||
                  (paddr == `RCS_STATUS_ADDR);
assign pslverr  = psel & penable & ~addr_ok;
assign wr_en    = psel & penable & pwrite & addr_ok;
assign rd_setup = psel & ~penable & ~pwrite;

// ============================================================
// oscillator_mode_reg: cleared by every system reset sequence
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        low_clock_select <= 1'b0;
    end else if (state == ST_HOLD || state == ST_INIT) begin
        // system registers back to initial values
        low_clock_select <= 1'b0;
    end else if (wr_en && paddr == `RCS_OSC_MODE_ADDR) begin
        low_clock_select <= pwdata[`RCS_LOW_CLK_BIT];
    end
end

// ============================================================
// configuration options survive system resets, like fused code options
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        div_code       <= `RCS_DIV_RESET;
        rst_pin_enable <= `RCS_RST_PIN_RESET;
    end else if (wr_en && paddr == `RCS_CONFIG_ADDR) begin
        div_code       <= pwdata[`RCS_DIV_MSB:`RCS_DIV_LSB];
        rst_pin_enable <= pwdata[`RCS_RST_PIN_EN_BIT];
    end
end

// ============================================================
// sticky reset cause flags; write one clears, a new cause wins
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cause_pin <= 1'b0;
        cause_wdt <= 1'b0;
    end else begin
        if (pin_reset) begin
            cause_pin <= 1'b1;
        end else if (wr_en && paddr == `RCS_STATUS_ADDR && pwdata[`RCS_CAUSE_PIN_BIT]) begin
            cause_pin <= 1'b0;
        end
        if (watchdog_overflow && (state == ST_RUN || state == ST_WARM)) begin
            cause_wdt <= 1'b1;
        end else if (wr_en && paddr == `RCS_STATUS_ADDR && pwdata[`RCS_CAUSE_WDT_BIT]) begin
            cause_wdt <= 1'b0;
        end
    end
end

// ============================================================
// read mux
assign rd_value =
    (paddr == `RCS_OSC_MODE_ADDR) ? ({31'h0, low_clock_select} << `RCS_LOW_CLK_BIT) :
    (paddr == `RCS_CONFIG_ADDR)   ? ({31'h0, rst_pin_enable} << `RCS_RST_PIN_EN_BIT) |
                                    {29'h0, div_code} :
    (paddr == `RCS_STATUS_ADDR)   ? ({31'h0, state == ST_RUN}  << `RCS_ST_RUN_BIT)  |
                                    ({31'h0, state == ST_WARM} << `RCS_ST_WARM_BIT) |
                                    ({31'h0, state == ST_HOLD} << `RCS_ST_HOLD_BIT) |
                                    ({31'h0, pin_sync}         << `RCS_ST_PIN_BIT)  |
                                    ({31'h0, cause_pin}        << `RCS_CAUSE_PIN_BIT) |
                                    ({31'h0, cause_wdt}        << `RCS_CAUSE_WDT_BIT) :
    32'h0000_0000;

// read data captured in the setup cycle, stable through the access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
        prdata <= rd_value;
    end
end

// ============================================================
// instruction clock divider
// terminal count 2^(code+1)-1, i.e. divide by 2..256
assign fast_last = (8'h02 << div_code) - 8'h01;

// counters run only while executing, so the first tick follows a whole period;
// a divider change mid-count wraps at once rather than running past the new limit
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fast_count       <= 8'h00;
        slow_count       <= 2'h0;
        fcpu_tick        <= 1'b0;
        low_clock_active <= 1'b0;
    end else begin
        // clock mode bit picks the source
        low_clock_active <= low_clock_select;
        fcpu_tick        <= 1'b0;
        if (state != ST_RUN) begin
            fast_count <= 8'h00;
            slow_count <= 2'h0;
        // slow source path; fixed divide by four
        end else if (low_clock_select) begin
            fast_count <= 8'h00;
            if (slow_internal_osc) begin
                if (slow_count == `RCS_SLOW_DIV_LAST) begin
                    slow_count <= 2'h0;
                    fcpu_tick  <= 1'b1;
                end else begin
                    slow_count <= slow_count + 2'h1;
                end
            end
        end else begin
            slow_count <= 2'h0;
            if (fast_count >= fast_last) begin
                fast_count <= 8'h00;
                fcpu_tick  <= 1'b1;
            end else begin
                fast_count <= fast_count + 8'h01;
            end
        end
    end
end

endmodule

//--- hw/reset_and_clock_select_regs.vh
// register map, field positions, reset values and timing counts of the reset and clock select block
`ifndef RESET_AND_CLOCK_SELECT_REGS_VH
`define RESET_AND_CLOCK_SELECT_REGS_VH

// ============================================================
// register byte offsets
`define RCS_OSC_MODE_ADDR   12'h000
`define RCS_CONFIG_ADDR     12'h004
`define RCS_STATUS_ADDR     12'h008
`define RCS_ADDR_W          12

// ============================================================
// oscillator_mode_reg fields
`define RCS_LOW_CLK_BIT     2

// ============================================================
// configuration register fields
`define RCS_DIV_LSB         0
`define RCS_DIV_MSB         2
`define RCS_RST_PIN_EN_BIT  3
`define RCS_DIV_RESET       3'h1
`define RCS_RST_PIN_RESET   1'h1

// ============================================================
// status register fields
`define RCS_ST_RUN_BIT      0
`define RCS_ST_WARM_BIT     1
`define RCS_ST_HOLD_BIT     2
`define RCS_ST_PIN_BIT      3
`define RCS_CAUSE_PIN_BIT   4
`define RCS_CAUSE_WDT_BIT   5

// ============================================================
// timing
`define RCS_WARM_PERIODS    11'h400
`define RCS_WARM_LAST       11'h3ff
`define RCS_SLOW_DIV_LAST   2'h3
`define RCS_RESET_VECTOR    10'h000

`endif

//--- bench/reset_supervisor_model.sv
// far-side reset supervisor that drives the external reset pin
`timescale 1ns/100ps
module reset_supervisor_model (
    // clock and hold request from the bench
    input  wire logic pclk,
    input  wire logic hold_req,
    // board reset line towards the device
    output logic      pin_n
);
    // ============================================================
    // pin follows the request one cycle late, like a slow supervisor
    initial pin_n = 1'b1;
    always @(posedge pclk) begin
        pin_n <= !hold_req;
    end
endmodule

//--- bench/reset_and_clock_select_monitor.sv
// concurrent checks on the reset and clock select ports
`timescale 1ns/100ps
`include "reset_and_clock_select_regs.vh"
module reset_and_clock_select_monitor (
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // reset sources
    input wire logic        ext_reset_n_pin,
    input wire logic        watchdog_overflow,
    // system side
    input wire logic        sys_init,
    input wire logic        cpu_run,
    input wire logic        cpu_start,
    input wire logic [9:0]  start_address,
    input wire logic        fcpu_tick,
    input wire logic        low_clock_active
);
    // ============================================================
    // helper state
    logic        pin_en;   // mirror of the reset pin option
    logic [11:0] warm_cnt; // cycles spent out of run since init
    // track option writes; wrap of warm_cnt only matters without init
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_en   <= 1'b1;
            warm_cnt <= 12'h000;
        end else begin
            if (psel && penable && pwrite && paddr == `RCS_CONFIG_ADDR)
                pin_en <= pwdata[`RCS_RST_PIN_EN_BIT];
            warm_cnt <= sys_init ? 12'h000 : warm_cnt + {11'h000, !cpu_run};
        end
    end
    // ============================================================
    // assertions
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    warm_len_a: assert property ($rose(cpu_run) |-> warm_cnt inside {[12'h3ff:12'h401]})
        else $error("warm-up length out of range");
    start_pulse_a: assert property (cpu_start == $rose(cpu_run))
        else $error("start pulse not tied to run entry");
    start_zero_a: assert property (cpu_start |-> start_address == `RCS_RESET_VECTOR)
        else $error("start address not zero");
    tick_gate_a: assert property (fcpu_tick |-> cpu_run || $past(cpu_run))
        else $error("instruction tick outside run");
    fast_space_a: assert property (fcpu_tick && !low_clock_active |=> !fcpu_tick)
        else $error("fast ticks closer than two cycles");
    pin_hold_a: assert property ((pin_en && !ext_reset_n_pin) [*3] |=> !cpu_run)
        else $error("low pin did not stop the core");
    pin_ignore_a: assert property (!pin_en && cpu_run && !watchdog_overflow |=> cpu_run)
        else $error("core left run with pin disabled");
    wdt_restart_a: assert property (cpu_run && watchdog_overflow && ext_reset_n_pin
        && $past(ext_reset_n_pin) && $past(ext_reset_n_pin, 2) |=> sys_init && !cpu_run)
        else $error("overflow did not restart sequence");
endmodule

bind reset_and_clock_select reset_and_clock_select_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .ext_reset_n_pin(ext_reset_n_pin),
    .watchdog_overflow(watchdog_overflow), .sys_init(sys_init), .cpu_run(cpu_run),
    .cpu_start(cpu_start), .start_address(start_address), .fcpu_tick(fcpu_tick),
    .low_clock_active(low_clock_active));

//--- bench/reset_and_clock_select_test.sv
// self-checking bench for the reset and clock select block
`timescale 1ns/100ps
module reset_and_clock_select_test;
    // ============================================================
    // signals
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        watchdog_overflow = 1'b0, hold_req = 1'b0, slow_internal_osc = 1'b0;
    logic [2:0]  slow_cnt = 3'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pin_n, pready, pslverr, sys_reset_n, sys_init, cpu_run, cpu_start, fcpu_tick, low_clock_active;
    logic [9:0]  start_address;
    logic [63:0] expq[$];   // mask and value of each pending read
    integer      seed = 32'h79aceecf;
    int          failures = 0, tests_run = 0, n, p;
    // ============================================================
    // clock and slow oscillator pulse every fifth cycle
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        slow_cnt          <= (slow_cnt == 3'h4) ? 3'h0 : slow_cnt + 3'h1;
        slow_internal_osc <= (slow_cnt == 3'h4);
    end
    reset_supervisor_model supervisor (.pclk(pclk), .hold_req(hold_req), .pin_n(pin_n));
    reset_and_clock_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_reset_n_pin(pin_n), .watchdog_overflow(watchdog_overflow), .slow_internal_osc(slow_internal_osc),
        .sys_reset_n(sys_reset_n), .sys_init(sys_init), .cpu_run(cpu_run), .cpu_start(cpu_start),
        .start_address(start_address), .fcpu_tick(fcpu_tick), .low_clock_active(low_clock_active));
    // ============================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer, then an idle cycle so psel never toggles twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        if (!wr)
            expq.push_back({m, d});
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wr ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // error response only for offsets beyond the status register
        check(pslverr, a > 12'h008);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // cycles until the next instruction tick, or until run
    task automatic wait_sig(input logic run, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while ((run ? cpu_run : fcpu_tick) !== 1'b1);
    endtask
    // read results are matched against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            check(prdata & expq[0][63:32], expq[0][31:0]);
            void'(expq.pop_front());
        end
    end
    // hang guard
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        conclude();
    end
    // ============================================================
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_sig(1'b1, n);
        check(n >= 1024 && n <= 1040, 1'b1);
        apb(1'b0, 12'h000, 32'h0, 32'h4);
        apb(1'b0, 12'h004, 32'h9, 32'hf);
        apb(1'b0, 12'h008, 32'h9, 32'hf);
        apb(1'b1, 12'h010, $random(seed), 32'h0);
        apb(1'b0, 12'h00c, 32'h0, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h004, 32'h8 | i, 32'h0);
            wait_sig(1'b0, p);
            wait_sig(1'b0, p);
            check(p, 2 << i);
        end
        apb(1'b1, 12'h000, 32'h4, 32'h0);
        apb(1'b0, 12'h000, 32'h4, 32'h4);
        check(low_clock_active, 1'b1);
        wait_sig(1'b0, p);
        wait_sig(1'b0, p);
        check(p, 20);
        apb(1'b1, 12'h000, 32'h0, 32'h0);
        hold_req <= 1'b1;
        repeat (30) @(posedge pclk);
        check({cpu_run, sys_reset_n, low_clock_active}, 3'b000);
        hold_req <= 1'b0;
        wait_sig(1'b1, n);
        check(n >= 1024 && n <= 1040, 1'b1);
        apb(1'b0, 12'h008, 32'h10, 32'h10);
        apb(1'b1, 12'h004, 32'h1, 32'h0);
        hold_req <= 1'b1;
        repeat (10) @(posedge pclk);
        check(cpu_run, 1'b1);
        hold_req <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, 12'h004, 32'h9, 32'h0);
        watchdog_overflow <= 1'b1;
        @(posedge pclk);
        watchdog_overflow <= 1'b0;
        @(posedge pclk);
        check({sys_init, cpu_run}, 2'b10);
        wait_sig(1'b1, n);
        apb(1'b0, 12'h008, 32'h21, 32'h21);
        // write one clears both cause flags
        apb(1'b1, 12'h008, 32'h30, 32'h0);
        apb(1'b0, 12'h008, 32'h0, 32'h30);
        conclude();
    end
endmodule
